// ### src/ppm_seq.sv
/*
 * Power-management sequencer of the link: ASPM capability, programmed
 * L0/L1/L3 link states, function power state and request throttling.
 * Assumes every input comes from logic on the core clock.
 */
// Operation
// - Advertise fast-training-sequence count of 255
// - ASPM autonomous, L0s only, never L1
// - No ASPM in non-synchronous clocking mode
// - L0s only on first/second-generation builds
// - Programmed states L0, L1 and L3
// - Enter L0 only after training completes
// - Non-D0 power state write starts L1
// - Programmed power state on status output
// - Ready low outside D0, finish open packet
// - Exchange L1 entry packets without user
// - Turn-off message moves link to L23
// - Interrupt held until user acknowledges
// - Poll acknowledge, then send turn-off acknowledge
// - After handshake, close interfaces, disable layers
`timescale 1ns/1ps
`default_nettype none
module ppm_seq
   import ppm_pkg::*;
#(
   parameter bit SUPPORT_D1 = 1'b0,
   parameter bit SUPPORT_D2 = 1'b0
)(
   // Clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_nrst,
   // Build options, static after reset
   input  wire logic       i_async_clk_mode,
   input  wire logic       i_gen3_target,
   // Link side
   input  wire logic       i_link_trained,
   input  wire logic       i_pwr_wr_valid,
   input  wire logic [1:0] i_pwr_wr_state,
   input  wire logic       i_l1_accepted,
   input  wire logic       i_turnoff_msg,
   // User request stream
   input  wire logic       i_rq_valid,
   input  wire logic       i_rq_last,
   // User handshake
   input  wire logic       i_power_change_ack,
   // Status and control outputs
   output logic [7:0]      o_nfts,
   output logic            o_aspm_l0s_en,
   output logic            o_aspm_l1_en,
   output logic [5:0]      o_link_state,
   output logic [1:0]      o_function_power_state,
   output logic            o_request_stream_ready,
   output logic            o_pm_enter_l1,
   output logic            o_turnoff_notice,
   output logic            o_turnoff_ack_send,
   output logic            o_layers_disabled
);

   ppm_hs_if hs_if ();

   ppm_link_e  link_ff;
   ppm_link_e  nxt_link;
   logic [1:0] pstate_ff;
   logic [1:0] nxt_pstate;
   logic       pkt_open_ff;
   logic       nxt_pkt_open;
   logic       ready_ff;
   logic       nxt_ready;
   logic       l1_req_ff;
   logic       nxt_l1_req;
   logic       cap_done_ff;
   logic       nxt_cap_done;
   logic       l0s_en_ff;
   logic       nxt_l0s_en;
   logic [7:0] nfts_ff;
   logic [7:0] nxt_nfts;
   logic       l1_en_ff;
   logic       nxt_l1_en;
   logic       wr_ok;
   logic       beat;

   // Unsupported D1/D2 writes are ignored, the state stays put
   assign wr_ok = i_pwr_wr_valid && ((i_pwr_wr_state == PPM_D0) || (i_pwr_wr_state == PPM_D3HOT) ||
                  ((i_pwr_wr_state == PPM_D1) && SUPPORT_D1) || ((i_pwr_wr_state == PPM_D2) && SUPPORT_D2));
   assign beat  = i_rq_valid && ready_ff;

   assign hs_if.turnoff_msg = i_turnoff_msg;
   assign hs_if.user_ack    = i_power_change_ack;

   ppm_turnoff u_turnoff (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .hs         (hs_if.hs)
   );

   // Power state and request throttling
   always_comb begin
      nxt_pstate = pstate_ff;
      if (wr_ok) begin
         nxt_pstate = i_pwr_wr_state;
      end
      nxt_pkt_open = pkt_open_ff;
      if (beat) begin
         nxt_pkt_open = !i_rq_last;
      end
      // An open packet keeps ready high so it is taken whole
      nxt_ready = ((nxt_pstate == PPM_D0) && (link_ff == PPM_LNK_L0) && !hs_if.powered_off) ||
                  (nxt_pkt_open && !hs_if.powered_off);
   end

   // Link state sequencing
   always_comb begin
      nxt_link   = link_ff;
      nxt_l1_req = 1'b0;
      if (hs_if.powered_off) begin
         nxt_link = PPM_LNK_L3;
      end else if (i_turnoff_msg || hs_if.turnoff_notice) begin
         nxt_link = PPM_LNK_L23;
      end else begin
         unique case (link_ff)
            PPM_LNK_TRAIN: begin
               if (i_link_trained) begin
                  nxt_link = PPM_LNK_L0;
               end
            end
            PPM_LNK_L0: begin
               if (!i_link_trained) begin
                  nxt_link = PPM_LNK_TRAIN;
               end else if ((pstate_ff != PPM_D0) && !pkt_open_ff) begin
                  nxt_link   = PPM_LNK_L1ENT;
                  nxt_l1_req = 1'b1;
               end
            end
            PPM_LNK_L1ENT: begin
               if (i_l1_accepted) begin
                  nxt_link = PPM_LNK_L1;
               end
            end
            PPM_LNK_L1: begin
               // Waits in L1 while training is lost, so L0 always follows a trained link
               if ((pstate_ff == PPM_D0) && i_link_trained) begin
                  nxt_link = PPM_LNK_L0;
               end
            end
            PPM_LNK_L23: begin
               nxt_link = PPM_LNK_L23;
            end
            PPM_LNK_L3: begin
               nxt_link = PPM_LNK_L3;
            end
            default: begin
               nxt_link = PPM_LNK_TRAIN;
            end
         endcase
      end
   end

   // Build options caught once, first cycle after reset release
   always_comb begin
      nxt_cap_done = 1'b1;
      nxt_l0s_en   = l0s_en_ff;
      // Held in flops so that every output leaves a register
      nxt_nfts     = PPM_NFTS_COUNT;
      nxt_l1_en    = 1'b0;
      if (!cap_done_ff) begin
         nxt_l0s_en = !i_async_clk_mode && !i_gen3_target;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         link_ff     <= PPM_LNK_TRAIN;
         pstate_ff   <= PPM_PS_RST;
         pkt_open_ff <= 1'b0;
         ready_ff    <= 1'b0;
         l1_req_ff   <= 1'b0;
         cap_done_ff <= 1'b0;
         l0s_en_ff   <= 1'b0;
         nfts_ff     <= PPM_NFTS_COUNT;
         l1_en_ff    <= 1'b0;
      end else begin
         link_ff     <= nxt_link;
         pstate_ff   <= nxt_pstate;
         pkt_open_ff <= nxt_pkt_open;
         ready_ff    <= nxt_ready;
         l1_req_ff   <= nxt_l1_req;
         cap_done_ff <= nxt_cap_done;
         l0s_en_ff   <= nxt_l0s_en;
         nfts_ff     <= nxt_nfts;
         l1_en_ff    <= nxt_l1_en;
      end
   end

   assign o_nfts                 = nfts_ff;
   assign o_aspm_l0s_en          = l0s_en_ff;
   assign o_aspm_l1_en           = l1_en_ff;
   assign o_link_state           = link_ff;
   assign o_function_power_state = pstate_ff;
   assign o_request_stream_ready = ready_ff;
   assign o_pm_enter_l1          = l1_req_ff;
   assign o_turnoff_notice       = hs_if.turnoff_notice;
   assign o_turnoff_ack_send     = hs_if.to_ack_send;
   assign o_layers_disabled      = hs_if.powered_off;

   nfts_fixed_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_nfts == 8'hFF)
      else $error("advertised fast-training count is not 255");

   no_aspm_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      cap_done_ff && (i_async_clk_mode || i_gen3_target) && $stable(i_async_clk_mode) |-> !l0s_en_ff)
      else $error("L0s offered in a configuration that forbids it");

   l0_after_train_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      $rose(link_ff == PPM_LNK_L0) |-> $past(i_link_trained) &&
      ($past(link_ff) == PPM_LNK_TRAIN || $past(link_ff) == PPM_LNK_L1))
      else $error("L0 reached without training");

   pstate_write_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      wr_ok |=> o_function_power_state == $past(i_pwr_wr_state))
      else $error("accepted power state write not shown");

   ready_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (pstate_ff != PPM_D0) && !pkt_open_ff && !(beat && !i_rq_last) && !wr_ok |=> !ready_ff)
      else $error("request ready high outside D0 with no open packet");

   open_pkt_kept_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      beat && !i_rq_last && !hs_if.powered_off ##1 !hs_if.powered_off |-> ready_ff)
      else $error("open packet cut off");

   l1_entry_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      link_ff == PPM_LNK_L1ENT && !i_l1_accepted && !i_turnoff_msg && !hs_if.turnoff_notice
      |=> link_ff == PPM_LNK_L1ENT)
      else $error("L1 entered before link partner agreed");

   l23_entry_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      i_turnoff_msg && !o_turnoff_notice && !o_turnoff_ack_send && !hs_if.powered_off
      |=> link_ff == PPM_LNK_L23 && o_turnoff_notice)
      else $error("turn-off message did not move link to L23");

endmodule
`default_nettype wire

// ### src/ppm_pkg.sv
/*
 * Shared constants and state types of the power-management handshake block.
 * Assumes nothing of its surroundings.
 */
package ppm_pkg;

   // Function power state encoding
   localparam logic [1:0] PPM_D0     = 2'h0;
   localparam logic [1:0] PPM_D1     = 2'h1;
   localparam logic [1:0] PPM_D2     = 2'h2;
   localparam logic [1:0] PPM_D3HOT  = 2'h3;
   localparam logic [1:0] PPM_PS_RST = 2'h0;

   // Advertised fast-training-sequence count
   localparam logic [7:0] PPM_NFTS_COUNT = 8'hFF;

   // Link states, one-hot
   typedef enum logic [5:0] {
      PPM_LNK_TRAIN = 6'h01,
      PPM_LNK_L0    = 6'h02,
      PPM_LNK_L1ENT = 6'h04,
      PPM_LNK_L1    = 6'h08,
      PPM_LNK_L23   = 6'h10,
      PPM_LNK_L3    = 6'h20
   } ppm_link_e;

   // Turn-off handshake states, one-hot
   typedef enum logic [3:0] {
      PPM_TO_IDLE   = 4'h1,
      PPM_TO_NOTIFY = 4'h2,
      PPM_TO_ACK    = 4'h4,
      PPM_TO_OFF    = 4'h8
   } ppm_to_e;

endpackage

// ### src/ppm_hs_if.sv
/*
 * Carrier between the link sequencer and the turn-off handshake.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface ppm_hs_if;
   logic turnoff_msg;
   logic user_ack;
   logic turnoff_notice;
   logic to_ack_send;
   logic powered_off;

   modport seq (output turnoff_msg, output user_ack,
                input turnoff_notice, input to_ack_send, input powered_off);
   modport hs  (input turnoff_msg, input user_ack,
                output turnoff_notice, output to_ack_send, output powered_off);
endinterface
`default_nettype wire

// ### src/ppm_turnoff.sv
/*
 * Turn-off handshake: notice to the user, wait for acknowledge,
 * send turn-off acknowledge upstream, then stay off.
 * Assumes single-cycle turn-off message pulses on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ppm_turnoff
   import ppm_pkg::*;
(
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_nrst,
   // Sequencer side
   ppm_hs_if.hs      hs
);

   ppm_to_e state_ff;
   ppm_to_e nxt_state;
   logic    notice_ff;
   logic    nxt_notice;
   logic    ack_send_ff;
   logic    nxt_ack_send;
   logic    off_ff;
   logic    nxt_off;

   always_comb begin
      nxt_state    = state_ff;
      nxt_ack_send = 1'b0;
      unique case (state_ff)
         PPM_TO_IDLE: begin
            if (hs.turnoff_msg) begin
               nxt_state = PPM_TO_NOTIFY;
            end
         end
         PPM_TO_NOTIFY: begin
            // Acknowledge polled every cycle
            if (hs.user_ack) begin
               nxt_state    = PPM_TO_ACK;
               nxt_ack_send = 1'b1;
            end
         end
         PPM_TO_ACK: begin
            nxt_state = PPM_TO_OFF;
         end
         PPM_TO_OFF: begin
            // Only reset leaves the off state
            nxt_state = PPM_TO_OFF;
         end
         default: begin
            nxt_state = PPM_TO_IDLE;
         end
      endcase
      nxt_notice = (nxt_state == PPM_TO_NOTIFY);
      nxt_off    = (nxt_state == PPM_TO_OFF);
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff    <= PPM_TO_IDLE;
         notice_ff   <= 1'b0;
         ack_send_ff <= 1'b0;
         off_ff      <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         notice_ff   <= nxt_notice;
         ack_send_ff <= nxt_ack_send;
         off_ff      <= nxt_off;
      end
   end

   assign hs.turnoff_notice = notice_ff;
   assign hs.to_ack_send    = ack_send_ff;
   assign hs.powered_off    = off_ff;

   notice_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      notice_ff && !hs.user_ack |=> notice_ff)
      else $error("turn-off notice dropped before acknowledge");

   ack_sends_msg_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      notice_ff && hs.user_ack |=> ack_send_ff && !notice_ff ##1 off_ff && !ack_send_ff)
      else $error("acknowledge did not lead to turn-off acknowledge then off");

   off_sticky_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      off_ff |=> off_ff && !notice_ff)
      else $error("left the powered-off state");

endmodule
`default_nettype wire

// ### test/ppm_user_model.sv
/* User application partner: answers the turn-off notice.
   Assumes the core clock and reset of the bench. */
`timescale 1ns/1ps
`default_nettype none
module ppm_user_model #(
   parameter int ACK_DELAY = 5
)(
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_nrst,
   // Handshake
   input  wire logic i_turnoff_notice,
   output logic      o_power_change_ack
);
   int cnt_ff;
   // Ack never drops: once given, the user is committed to power-off
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_ff <= 0;
         o_power_change_ack <= 1'b0;
      end else if (i_turnoff_notice) begin
         cnt_ff <= cnt_ff + 1;
         if (cnt_ff == ACK_DELAY) o_power_change_ack <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### test/tb_pcie_power_mgmt_handshake.sv
/* Bench of the power-management sequencer.
   Assumes default build parameters and the user partner model. */
`timescale 1ns/1ps
`default_nettype none
module tb_pcie_power_mgmt_handshake;
   import ppm_pkg::*;
   localparam int ACK_DLY = 5;
   logic clk, nrst, async_m, gen3, trained, wr_v, l1_acc, to_msg, rq_v, rq_l, ack;
   logic l0s, l1en, rdy, enter_l1, notice, ack_send, off;
   logic [1:0] wr_s;
   logic [1:0] fps;
   logic [5:0] lnk;
   logic [7:0] nfts;
   int   err_total;
   int   checks_done;
   // Build rows: async, gen3, expected L0s enable
   logic [2:0] opt_rows [4] = '{3'h1, 3'h4, 3'h2, 3'h6};
   // Write rows: state, expected power state, expected ready
   logic [4:0] wr_rows [3] = '{5'h09, 5'h11, 5'h01};

   ppm_seq u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_async_clk_mode(async_m),
      .i_gen3_target(gen3), .i_link_trained(trained), .i_pwr_wr_valid(wr_v),
      .i_pwr_wr_state(wr_s), .i_l1_accepted(l1_acc), .i_turnoff_msg(to_msg),
      .i_rq_valid(rq_v), .i_rq_last(rq_l), .i_power_change_ack(ack), .o_nfts(nfts),
      .o_aspm_l0s_en(l0s), .o_aspm_l1_en(l1en), .o_link_state(lnk),
      .o_function_power_state(fps), .o_request_stream_ready(rdy),
      .o_pm_enter_l1(enter_l1), .o_turnoff_notice(notice),
      .o_turnoff_ack_send(ack_send), .o_layers_disabled(off));
   ppm_user_model #(.ACK_DELAY(ACK_DLY)) u_user (.i_core_clk(clk), .i_nrst(nrst),
      .i_turnoff_notice(notice), .o_power_change_ack(ack));

   task automatic give_verdict();
      if (err_total == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic do_reset();
      nrst = 1'b0;
      cyc(16);
      nrst = 1'b1;
      cyc(3);
   endtask
   // Bounded wait on L1 request (pick 0) or turn-off acknowledge (pick 1)
   task automatic wait_hi(input bit pick, input int lim);
      int n;
      n = 0;
      while ((pick ? ack_send : enter_l1) !== 1'b1) begin
         if (n == lim) begin
            err_total++;
            give_verdict();
         end
         cyc(1);
         n++;
      end
   endtask
   task automatic pwr_wr(input logic [1:0] s);
      wr_s = s;
      wr_v = 1'b1;
      cyc(1);
      wr_v = 1'b0;
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      {async_m, gen3, trained, wr_v, l1_acc, to_msg, rq_v, rq_l} = 8'h00;
      wr_s = PPM_D0;
      nrst = 1'b0;
      err_total = 0;
      checks_done = 0;
      // Build options are sampled once, so each row needs a fresh reset
      for (int i = 0; i < 4; i++) begin
         {async_m, gen3} = opt_rows[i][2:1];
         do_reset();
         chk("l0s_en", opt_rows[i][0], l0s);
      end
      chk("nfts", 8'hFF, nfts);
      chk("l1_en", 8'h00, l1en);
      chk("train", PPM_LNK_TRAIN, lnk);
      trained = 1'b1;
      cyc(2);
      chk("l0", PPM_LNK_L0, lnk);
      // Training lost in L0 sends the link back to training
      trained = 1'b0;
      cyc(1);
      chk("retrain", PPM_LNK_TRAIN, lnk);
      trained = 1'b1;
      cyc(2);
      chk("l0_again", PPM_LNK_L0, lnk);
      chk("rdy_l0", 8'h01, rdy);
      foreach (wr_rows[i]) begin
         pwr_wr(wr_rows[i][4:3]);
         chk("fps", wr_rows[i][2:1], fps);
         chk("rdy", wr_rows[i][0], rdy);
      end
      // Packet opened in D0, then D3-hot written mid-packet
      rq_v = 1'b1;
      cyc(1);
      rq_v = 1'b0;
      pwr_wr(PPM_D3HOT);
      chk("fps_d3", PPM_D3HOT, fps);
      cyc(2);
      chk("rdy_open", 8'h01, rdy);
      chk("l0_open", PPM_LNK_L0, lnk);
      rq_v = 1'b1;
      rq_l = 1'b1;
      cyc(1);
      rq_v = 1'b0;
      rq_l = 1'b0;
      wait_hi(1'b0, 4);
      chk("l1_entry", PPM_LNK_L1ENT, lnk);
      chk("rdy_closed", 8'h00, rdy);
      cyc(1);
      chk("enter_pulse", 8'h00, enter_l1);
      l1_acc = 1'b1;
      cyc(1);
      l1_acc = 1'b0;
      chk("l1", PPM_LNK_L1, lnk);
      pwr_wr(PPM_D0);
      cyc(2);
      chk("back_l0", PPM_LNK_L0, lnk);
      chk("rdy_d0", 8'h01, rdy);
      to_msg = 1'b1;
      cyc(1);
      to_msg = 1'b0;
      chk("l23", PPM_LNK_L23, lnk);
      repeat (ACK_DLY) begin
         chk("notice_held", 8'h01, notice);
         cyc(1);
      end
      wait_hi(1'b1, 4);
      chk("notice_drop", 8'h00, notice);
      cyc(1);
      chk("ack_pulse", 8'h00, ack_send);
      chk("off", 8'h01, off);
      chk("rdy_off", 8'h00, rdy);
      // A late turn-off message must not restart the handshake
      to_msg = 1'b1;
      cyc(1);
      to_msg = 1'b0;
      cyc(1);
      chk("l3", PPM_LNK_L3, lnk);
      chk("notice_again", 8'h00, notice);
      do_reset();
      chk("off_reset", 8'h00, off);
      give_verdict();
   end
endmodule
`default_nettype wire
